// *** rtl/mas_pkg.sv ***
// Constants and carrier types for the microcode address sequencer.
// Assumes one common clock; every user of these names writes mas_pkg::name.
package mas_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int MUX_N = 6;
   localparam int ROWS_N = 8;
   localparam int EXP_W = 8;
   localparam int PADDR_W = 12;
   localparam int CS_DEPTH = 256;
   localparam int CS_WORD_W = 64;

   // ----------------------------------------------------------------
   // Trap vectors (octal 0, 4, 10, 20 and the idle entry 3)
   // ----------------------------------------------------------------
   localparam logic [7:0] VEC_INIT = 8'h00;
   localparam logic [7:0] VEC_BRK = 8'h04;
   localparam logic [7:0] VEC_ABORT = 8'h08;
   localparam logic [7:0] VEC_NEGZERO = 8'h10;
   localparam logic [7:0] VEC_IDLE = 8'h03;

   // Branch-select value that disables every multiplexer
   localparam logic [2:0] SEL_NONE = 3'h7;
   localparam logic [1:0] TGT_WIDE = 2'h0;
   localparam logic [1:0] TGT_MUX0 = 2'h1;
   localparam logic [1:0] TGT_MUX1 = 2'h2;
   localparam logic [1:0] TGT_BOTH = 2'h3;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_BREAK = 12'h004;
   localparam logic [11:0] OFS_STATUS = 12'h008;

   // Field positions
   localparam int CTRL_MAINT_BIT = 0;
   localparam int STAT_ADDR_LSB = 0;
   localparam int STAT_FLAGS_LSB = 8;
   localparam int STAT_IDLE_BIT = 12;

   // Reset values
   localparam logic [7:0] RST_ADDR = 8'h00;
   localparam logic RST_MAINT = 1'b0;
   localparam logic [7:0] RST_BREAK = 8'h00;
   localparam logic [31:0] RST_PRDATA = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] next_addr;
      logic [2:0] branch_select_field;
      logic [1:0] branch_target_field;
      logic jump_enable_field;
   } mas_uword_t;

   typedef struct packed {
      logic negative_zero;
      logic abort;
      logic breakpoint;
      logic init;
   } mas_traps_t;

   // Row r, column c: condition fed to input r of multiplexer c
   typedef logic [ROWS_N-1:0][MUX_N-1:0] mas_cond_t;

endpackage : mas_pkg

// *** rtl/mas_branch_mux.sv ***
// Six branch-condition multiplexers with their enable decode.
// Assumes condition rows are on the sequencer clock; purely combinational.
`timescale 1ns/1ns
module mas_branch_mux (
   input wire mas_pkg::mas_cond_t cond,
   input wire logic [2:0] branch_select_field,
   input wire logic [1:0] branch_target_field,
   input wire logic trap_pending,
   output logic [5:0] mux_out
);

   logic [5:0] enable;
   logic upper_mux_group_enable;

   // ----------------------------------------------------------------
   // Enable decode
   // ----------------------------------------------------------------
   // Traps suppress the wide group so a vector is never disturbed
   assign upper_mux_group_enable = (branch_target_field == mas_pkg::TGT_WIDE) & ~trap_pending;

   always_comb begin
      enable = 6'h00;
      enable[5:2] = {4{upper_mux_group_enable}};
      case (branch_target_field)
         mas_pkg::TGT_WIDE: begin
            enable[1:0] = {2{~branch_select_field[0]}};
         end
         mas_pkg::TGT_MUX0: begin
            enable[0] = 1'b1;
         end
         mas_pkg::TGT_MUX1: begin
            enable[1] = 1'b1;
         end
         mas_pkg::TGT_BOTH: begin
            enable[1:0] = 2'h3;
         end
         default: begin
            enable = 6'h00;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Multiplexers
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < mas_pkg::MUX_N; gi++) begin : g_mux
         // Select zero picks row A, the opcode and fraction-subtract row
         assign mux_out[gi] = enable[gi]
            & (branch_select_field != mas_pkg::SEL_NONE)
            & cond[branch_select_field][gi];
      end
   endgenerate

endmodule : mas_branch_mux

// *** rtl/mas_sequencer.sv ***
// Control-store address sequencer with trap vectors and an APB slave.
// Assumes the control word and datapath conditions come from pclk logic;
// initialize and the two abort inputs are asynchronous and are synchronised.
`timescale 1ns/1ns
module mas_sequencer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire mas_pkg::mas_uword_t uword,
   input wire mas_pkg::mas_cond_t cond,
   input wire logic idle_state,
   input wire logic accumulator_multiplexer_sign,
   input wire logic [7:0] accumulator_multiplexer_exponent,
   input wire logic init_async,
   input wire logic cpu_abort_async,
   input wire logic host_abort_async,
   input wire mas_pkg::mas_traps_t trap_clear,
   output logic [7:0] control_store_address_reg,
   output mas_pkg::mas_traps_t trap_flags,
   output logic return_idle_request
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [2:0] sync1_q;
   logic [2:0] sync2_q;
   logic [7:0] addr_q;
   logic [7:0] addr_d;
   mas_pkg::mas_traps_t flags_q;
   mas_pkg::mas_traps_t flags_d;
   mas_pkg::mas_traps_t cause;
   logic idle_q;
   logic maint_q;
   logic [7:0] break_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic [5:0] mux_out;
   logic trap_low_bits_inhibit;
   logic trap_high_bits_inhibit;
   logic go_idle;
   logic negative_zero_condition;
   logic [7:0] vector;
   logic [7:0] branched;
   logic setup;
   logic access;
   logic hit_ctrl;
   logic hit_break;
   logic hit_status;

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   // Order: 0 init, 1 cpu abort, 2 host abort
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= 3'h0;
         sync2_q <= 3'h0;
      end else begin
         sync1_q <= {host_abort_async, cpu_abort_async, init_async};
         sync2_q <= sync1_q;
      end
   end

   // ----------------------------------------------------------------
   // Trap detection
   // ----------------------------------------------------------------
   // Complement-form data: a set sign with a zero exponent is minus zero
   assign negative_zero_condition = accumulator_multiplexer_sign & (accumulator_multiplexer_exponent == 8'h00);

   always_comb begin
      cause = '0;
      if (sync2_q[0] & sync2_q[1]) begin
         cause.init = 1'b1;
      end else if (maint_q & ~idle_state & (break_q == addr_q)) begin
         cause.breakpoint = 1'b1;
      end else if (sync2_q[2]) begin
         cause.abort = 1'b1;
      end else if (negative_zero_condition) begin
         cause.negative_zero = 1'b1;
      end
   end

   always_comb begin
      vector = 8'h00;
      case (1'b1)
         cause.init: begin
            vector = mas_pkg::VEC_INIT;
         end
         cause.breakpoint: begin
            vector = mas_pkg::VEC_BRK;
         end
         cause.abort: begin
            vector = mas_pkg::VEC_ABORT;
         end
         cause.negative_zero: begin
            vector = mas_pkg::VEC_NEGZERO;
         end
         default: begin
            vector = mas_pkg::VEC_IDLE;
         end
      endcase
   end

   assign trap_low_bits_inhibit = |cause;
   assign go_idle = uword.jump_enable_field & (uword.next_addr[1:0] == 2'h3)
      & ~trap_low_bits_inhibit;
   assign trap_high_bits_inhibit = trap_low_bits_inhibit | go_idle;

   // ----------------------------------------------------------------
   // Branch multiplexers
   // ----------------------------------------------------------------
   mas_branch_mux u_mux (
      .cond(cond),
      .branch_select_field(uword.branch_select_field),
      .branch_target_field(uword.branch_target_field),
      .trap_pending(trap_low_bits_inhibit),
      .mux_out(mux_out)
   );

   // ----------------------------------------------------------------
   // Next address
   // ----------------------------------------------------------------
   // The top two bits never see a multiplexer
   assign branched = uword.next_addr | {2'h0, mux_out};

   always_comb begin
      addr_d = branched;
      if (trap_high_bits_inhibit) begin
         addr_d[7:2] = vector[7:2];
      end
      if (trap_low_bits_inhibit) begin
         addr_d[1:0] = 2'h0;
      end else if (go_idle) begin
         addr_d[1:0] = mas_pkg::VEC_IDLE[1:0];
      end
   end

   // Eight bits reach every word of the 256-deep store
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_q <= mas_pkg::RST_ADDR;
         idle_q <= 1'b0;
      end else begin
         addr_q <= addr_d;
         idle_q <= go_idle;
      end
   end

   // ----------------------------------------------------------------
   // Sticky trap flags
   // ----------------------------------------------------------------
   // A new cause in the clearing cycle keeps its flag
   assign flags_d = (flags_q & ~trap_clear) | cause;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_q <= '0;
      end else begin
         flags_q <= flags_d;
      end
   end

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   // Ready is raised for the first access cycle, so no wait states
   assign setup = psel & ~penable;
   assign access = psel & penable & pready_q;
   assign hit_ctrl = (paddr == mas_pkg::OFS_CTRL);
   assign hit_break = (paddr == mas_pkg::OFS_BREAK);
   assign hit_status = (paddr == mas_pkg::OFS_STATUS);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= mas_pkg::RST_PRDATA;
      end else begin
         pready_q <= setup;
         pslverr_q <= setup & ~(hit_ctrl | hit_break | hit_status);
         prdata_q <= 32'h0000_0000;
         if (setup & ~pwrite) begin
            if (hit_ctrl) begin
               prdata_q[mas_pkg::CTRL_MAINT_BIT] <= maint_q;
            end
            if (hit_break) begin
               prdata_q[7:0] <= break_q;
            end
            if (hit_status) begin
               prdata_q[mas_pkg::STAT_ADDR_LSB +: 8] <= addr_q;
               prdata_q[mas_pkg::STAT_FLAGS_LSB +: 4] <= flags_q;
               prdata_q[mas_pkg::STAT_IDLE_BIT] <= idle_q;
            end
         end
      end
   end

   // Maintenance mode gates the microbreak comparison
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         maint_q <= mas_pkg::RST_MAINT;
      end else if (access & pwrite & hit_ctrl) begin
         maint_q <= pwdata[mas_pkg::CTRL_MAINT_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         break_q <= mas_pkg::RST_BREAK;
      end else if (access & pwrite & hit_break) begin
         break_q <= pwdata[7:0];
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign control_store_address_reg = addr_q;
   assign trap_flags = flags_q;
   assign return_idle_request = idle_q;
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_init_vector: assert property (@(posedge pclk) disable iff (!presetn)
      (sync2_q[0] & sync2_q[1]) |=> (addr_q == 8'h00) && flags_q.init)
      else $error("init trap did not vector to zero");

   a_break_vector: assert property (@(posedge pclk) disable iff (!presetn)
      (maint_q & ~idle_state & (break_q == addr_q) & ~(sync2_q[0] & sync2_q[1]))
      |=> (addr_q == 8'h04) && flags_q.breakpoint)
      else $error("microbreak did not vector to four");

   a_abort_vector: assert property (@(posedge pclk) disable iff (!presetn)
      (cause.abort) |=> (addr_q == 8'h08) && flags_q.abort && !return_idle_request)
      else $error("abort did not vector correctly");

   a_negzero_vector: assert property (@(posedge pclk) disable iff (!presetn)
      (accumulator_multiplexer_sign && accumulator_multiplexer_exponent == 8'h00 && !sync2_q[2] && !sync2_q[0] && !maint_q)
      |=> (addr_q == 8'h10) && flags_q.negative_zero)
      else $error("negative zero did not vector to octal twenty");

   a_idle_jump: assert property (@(posedge pclk) disable iff (!presetn)
      (uword.jump_enable_field && uword.next_addr[1:0] == 2'h3 && cause == '0)
      |=> (addr_q == 8'h03) && return_idle_request)
      else $error("return to idle did not load address three");

   a_or_only: assert property (@(posedge pclk) disable iff (!presetn)
      (!trap_high_bits_inhibit) |=> ((addr_q & $past(uword.next_addr)) == $past(uword.next_addr))
         && (addr_q[7:6] == $past(uword.next_addr[7:6])))
      else $error("branching cleared an address bit");

   a_plain_load: assert property (@(posedge pclk) disable iff (!presetn)
      (!trap_high_bits_inhibit && uword.branch_select_field == 3'h7)
      |=> addr_q == $past(uword.next_addr))
      else $error("unmodified next address not loaded");

   a_low_block: assert property (@(posedge pclk) disable iff (!presetn)
      (trap_low_bits_inhibit) |=> (addr_q[1:0] == 2'h0) && !return_idle_request)
      else $error("trap let low address bits through");

   a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      (flags_q.abort && !trap_clear.abort) |=> flags_q.abort [*1] ##1 1'b1)
      else $error("abort flag dropped without clear");

   a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> pready && (pslverr == !$past(hit_ctrl | hit_break | hit_status)))
      else $error("apb ready not raised after setup");

   a_mux_none: assert property (@(posedge pclk) disable iff (!presetn)
      (uword.branch_select_field == mas_pkg::SEL_NONE) |-> (mux_out == 6'h00))
      else $error("select seven still modified the address");

   a_mux0_only: assert property (@(posedge pclk) disable iff (!presetn)
      (uword.branch_target_field == mas_pkg::TGT_MUX0) |-> (mux_out[5:1] == 5'h00))
      else $error("target one enabled more than multiplexer zero");

   a_mux1_only: assert property (@(posedge pclk) disable iff (!presetn)
      (uword.branch_target_field == mas_pkg::TGT_MUX1)
      |-> (mux_out[5:2] == 4'h0) && !mux_out[0])
      else $error("target two enabled more than multiplexer one");

   a_odd_narrow: assert property (@(posedge pclk) disable iff (!presetn)
      (uword.branch_target_field == mas_pkg::TGT_WIDE && uword.branch_select_field[0])
      |-> (mux_out[1:0] == 2'h0))
      else $error("odd select reached multiplexers zero or one");

   a_row_a_pass: assert property (@(posedge pclk) disable iff (!presetn)
      (uword.branch_select_field == 3'h0 && uword.branch_target_field == mas_pkg::TGT_WIDE
      && cause == '0) |-> (mux_out == cond[0]))
      else $error("row A conditions not passed");

   a_negzero_needs: assert property (@(posedge pclk) disable iff (!presetn)
      (!accumulator_multiplexer_sign || accumulator_multiplexer_exponent != 8'h00) |-> !cause.negative_zero)
      else $error("negative zero trap without sign and zero exponent");

   a_break_gated: assert property (@(posedge pclk) disable iff (!presetn)
      (!maint_q || idle_state || break_q != addr_q) |-> !cause.breakpoint)
      else $error("microbreak outside maintenance or in idle");

   a_init_first: assert property (@(posedge pclk) disable iff (!presetn)
      (sync2_q[0] && sync2_q[1]) |-> cause.init && !cause.abort && !cause.breakpoint)
      else $error("init trap did not take priority");

   a_idle_upper: assert property (@(posedge pclk) disable iff (!presetn)
      (go_idle) |=> (addr_q[7:2] == 6'h00))
      else $error("return to idle kept upper address bits");

   a_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
      (cause.abort && trap_clear.abort) |=> flags_q.abort)
      else $error("abort flag lost to a clear in the same cycle");

endmodule : mas_sequencer

// *** sim/mas_cstore_model.sv ***
// Behavioural control store that feeds microwords to the sequencer.
// Assumes its address input is the sequencer's registered address.
`timescale 1ns/1ns
module mas_cstore_model (
   input wire logic [7:0] addr,
   output mas_pkg::mas_uword_t uword
);
   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [63:0] mem [mas_pkg::CS_DEPTH];

   // Unused words loop on themselves, so a parked sequencer stays put
   function automatic logic [63:0] idle_word(input logic [7:0] a);
      idle_word = 64'({a, mas_pkg::SEL_NONE, mas_pkg::TGT_WIDE, 1'b0});
   endfunction : idle_word

   initial begin
      for (int i = 0; i < mas_pkg::CS_DEPTH; i++) begin
         mem[i] = idle_word(8'(i));
      end
   end

   assign uword = mas_pkg::mas_uword_t'(mem[addr][13:0]);

   task automatic load(input logic [7:0] a, input mas_pkg::mas_uword_t w);
      mem[a] <= 64'(w);
   endtask : load

   task automatic park(input logic [7:0] a);
      mem[a] <= idle_word(a);
   endtask : park
endmodule : mas_cstore_model

// *** sim/tb_top.sv ***
// Self-checking bench for the microcode address sequencer.
// Assumes the package, the sequencer and the store model are compiled first.
`timescale 1ns/1ns
module tb_top;
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   mas_pkg::mas_uword_t uword;
   mas_pkg::mas_cond_t cond;
   logic idle_state;
   logic accumulator_multiplexer_sign;
   logic [7:0] accumulator_multiplexer_exponent;
   logic init_async;
   logic cpu_abort_async;
   logic host_abort_async;
   mas_pkg::mas_traps_t trap_clear;
   logic [7:0] addr;
   mas_pkg::mas_traps_t trap_flags;
   logic return_idle_request;
   int fails;
   int n_tests;
   logic [7:0] cur;

   mas_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .uword(uword), .cond(cond), .idle_state(idle_state),
      .accumulator_multiplexer_sign(accumulator_multiplexer_sign), .accumulator_multiplexer_exponent(accumulator_multiplexer_exponent), .init_async(init_async),
      .cpu_abort_async(cpu_abort_async), .host_abort_async(host_abort_async),
      .trap_clear(trap_clear), .control_store_address_reg(addr),
      .trap_flags(trap_flags), .return_idle_request(return_idle_request));
   mas_cstore_model u_cs (.addr(addr), .uword(uword));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : conclude

   function automatic mas_pkg::mas_uword_t uw(input logic [7:0] n, input logic [2:0] s,
      input logic [1:0] t, input logic j);
      uw = {n, s, t, j};
   endfunction : uw

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // Sampled before this edge's updates land, as the slave saw them
      // Only the watchdog ends a wait that never sees ready
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // The word is parked again once taken, so no stale word is replayed
   task automatic step(input mas_pkg::mas_uword_t w, input logic [7:0] exp);
      @(posedge pclk);
      u_cs.load(cur, w);
      @(posedge pclk);
      u_cs.park(cur);
      #1;
      cur = exp;
      chk(32'(addr), 32'(exp));
   endtask : step

   task automatic clr(input mas_pkg::mas_traps_t m);
      @(posedge pclk);
      trap_clear <= m;
      @(posedge pclk);
      trap_clear <= 4'h0;
      #1;
      chk(32'(trap_flags), 32'h0);
   endtask : clr

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_regs();
      logic [31:0] rd;
      logic err;
      apb(1'b0, mas_pkg::OFS_BREAK, 32'h0, rd, err);
      chk(rd, 32'h0000_0000);
      chk(32'(err), 32'h0000_0000);
      // A break value off the parked address keeps maintenance mode from trapping
      apb(1'b1, mas_pkg::OFS_BREAK, 32'hFFFF_FFA5, rd, err);
      apb(1'b0, mas_pkg::OFS_BREAK, 32'h0, rd, err);
      chk(rd, 32'h0000_00A5);
      apb(1'b1, mas_pkg::OFS_CTRL, 32'hFFFF_FFFF, rd, err);
      apb(1'b0, mas_pkg::OFS_CTRL, 32'h0, rd, err);
      chk(rd, 32'h0000_0001);
      apb(1'b1, mas_pkg::OFS_CTRL, 32'h0, rd, err);
      apb(1'b1, mas_pkg::OFS_STATUS, 32'hFFFF_FFFF, rd, err);
      apb(1'b0, mas_pkg::OFS_STATUS, 32'h0, rd, err);
      chk(rd, 32'h0000_0000);
      apb(1'b0, 12'h00C, 32'h0, rd, err);
      chk(rd, 32'h0000_0000);
      chk(32'(err), 32'h0000_0001);
      $display("done regs");
   endtask : t_regs

   task automatic t_branch();
      logic [5:0] en;
      logic [5:0] c;
      @(posedge pclk);
      for (int r = 0; r < 8; r++) cond[r] <= 6'(8'h0B * (r + 1));
      for (int s = 0; s < 8; s++) begin
         for (int t = 0; t < 4; t++) begin
            c = 6'(8'h0B * (s + 1));
            case (t)
               0: en = (s % 2 == 1) ? 6'h3C : 6'h3F;
               1: en = 6'h01;
               2: en = 6'h02;
               default: en = 6'h03;
            endcase
            if (s == 7) en = 6'h00;
            step(uw(8'h84, 3'(s), 2'(t), 1'b0), 8'h84 | {2'b00, en & c});
         end
      end
      $display("done branch");
   endtask : t_branch

   task automatic t_jump();
      step(uw(8'hF1, mas_pkg::SEL_NONE, mas_pkg::TGT_WIDE, 1'b1), 8'hF1);
      chk(32'(return_idle_request), 32'h0);
      step(uw(8'hF3, mas_pkg::SEL_NONE, mas_pkg::TGT_WIDE, 1'b1), 8'h03);
      chk(32'(return_idle_request), 32'h1);
      $display("done jump");
   endtask : t_jump

   task automatic t_negzero();
      @(posedge pclk);
      accumulator_multiplexer_sign <= 1'b1;
      accumulator_multiplexer_exponent <= 8'h01;
      step(uw(cur, mas_pkg::SEL_NONE, mas_pkg::TGT_WIDE, 1'b0), cur);
      @(posedge pclk);
      accumulator_multiplexer_exponent <= 8'h00;
      @(posedge pclk);
      #1;
      chk({24'h0, addr}, 32'(mas_pkg::VEC_NEGZERO));
      chk(32'(trap_flags), 32'h8);
      cur = mas_pkg::VEC_NEGZERO;
      @(posedge pclk);
      accumulator_multiplexer_sign <= 1'b0;
      clr(4'h8);
      $display("done negzero");
   endtask : t_negzero

   task automatic t_abort();
      @(posedge pclk);
      host_abort_async <= 1'b1;
      repeat (3) @(posedge pclk);
      #1;
      chk({24'h0, addr}, 32'(mas_pkg::VEC_ABORT));
      chk(32'(trap_flags), 32'h4);
      cur = mas_pkg::VEC_ABORT;
      step(uw(8'h0B, 3'h0, mas_pkg::TGT_BOTH, 1'b0), mas_pkg::VEC_ABORT);
      @(posedge pclk);
      trap_clear <= 4'h4;
      @(posedge pclk);
      trap_clear <= 4'h0;
      host_abort_async <= 1'b0;
      #1;
      chk(32'(trap_flags), 32'h4);
      repeat (3) @(posedge pclk);
      #1;
      chk(32'(trap_flags), 32'h4);
      clr(4'h4);
      $display("done abort");
   endtask : t_abort

   task automatic t_init();
      @(posedge pclk);
      init_async <= 1'b1;
      cpu_abort_async <= 1'b1;
      host_abort_async <= 1'b1;
      repeat (3) @(posedge pclk);
      #1;
      chk({24'h0, addr}, 32'(mas_pkg::VEC_INIT));
      chk(32'(trap_flags), 32'h1);
      cur = mas_pkg::VEC_INIT;
      @(posedge pclk);
      init_async <= 1'b0;
      cpu_abort_async <= 1'b0;
      host_abort_async <= 1'b0;
      repeat (3) @(posedge pclk);
      clr(4'h1);
      $display("done init");
   endtask : t_init

   task automatic t_break();
      logic [31:0] rd;
      logic err;
      apb(1'b1, mas_pkg::OFS_BREAK, 32'h0000_0040, rd, err);
      apb(1'b1, mas_pkg::OFS_CTRL, 32'h0000_0001, rd, err);
      @(posedge pclk);
      idle_state <= 1'b1;
      step(uw(8'h40, mas_pkg::SEL_NONE, mas_pkg::TGT_WIDE, 1'b0), 8'h40);
      step(uw(8'h40, mas_pkg::SEL_NONE, mas_pkg::TGT_WIDE, 1'b0), 8'h40);
      @(posedge pclk);
      idle_state <= 1'b0;
      @(posedge pclk);
      #1;
      chk({24'h0, addr}, 32'(mas_pkg::VEC_BRK));
      chk(32'(trap_flags), 32'h2);
      cur = mas_pkg::VEC_BRK;
      apb(1'b1, mas_pkg::OFS_CTRL, 32'h0, rd, err);
      clr(4'h2);
      $display("done break");
   endtask : t_break

   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      fails = 0;
      n_tests = 0;
      cur = 8'h00;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      cond = '0;
      {idle_state, accumulator_multiplexer_sign, accumulator_multiplexer_exponent} = '0;
      {init_async, cpu_abort_async, host_abort_async} = '0;
      trap_clear = 4'h0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_branch();
      t_jump();
      t_negzero();
      t_abort();
      t_init();
      t_break();
      conclude();
   end

   // About 150 cycles are needed; this leaves ample margin
   initial begin
      #(100 * 20000);
      fails++;
      $display("watchdog expired");
      conclude();
   end
endmodule : tb_top
